// ==== gds_dma_sync.sv ====
// dma request synchroniser, bus grant glue, adapter handshake sequencer and trap classifier
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`include "gds_dma_sync_regs.svh"

module gds_dma_sync (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // processor bus exchange
  input  wire logic        q_phase,
  input  wire logic        first_quarter_pulse,
  input  wire logic        bus_available,
  input  wire logic        bus_state_line,
  input  wire logic        dmac_drives_bus,
  input  wire logic [3:0]  periph_select_in,
  output logic             cpu_dma_bus_request,
  output logic             dmac_grant,
  output logic             dead_cycle_select_block,
  output logic [3:0]       periph_select_out,
  // dma controller
  input  wire logic        dmac_transfer_request,
  input  wire logic        dma_grant_in,
  input  wire logic        dmac_irq,
  output logic             channel_request_in,
  // adapter register port during dma
  input  wire logic [7:0]  mem_data_in,
  output logic [7:0]       mem_data_out,
  output logic [2:0]       reg_select,
  output logic             rw_inverted,
  // gpib handshake and data
  input  wire logic        eoi_n,
  input  wire logic        dav_in,
  input  wire logic        dac_in,
  input  wire logic [7:0]  gpib_data_in,
  output logic             rfd_out,
  output logic             dac_out,
  output logic             dav_out,
  output logic [7:0]       gpib_data_out,
  output logic             gpib_data_oe,
  // interrupt classification
  input  wire logic        irq_in,
  input  wire logic        adapter_int,
  input  wire logic        listener_addressed_flag,
  input  wire logic        talker_addressed_flag,
  input  wire logic        serial_poll_active_flag,
  output logic             adapter_irq,
  output logic [7:0]       trap_display
);

  // ---------------- ahb-lite slave ----------------
  gds_pkg::gds_aphase_s aph_ff;
  gds_pkg::gds_ctrl_s   ctrl_ff;
  logic [31:0]          hrdata_ff;
  logic                 restart_ff;

  wire logic addr_take = hsel & htrans[1] & hready;
  wire logic wr_data   = aph_ff.valid & aph_ff.write;
  wire logic wr_ctrl   = wr_data & (aph_ff.addr == 4'(`GDS_OFS_CTRL));
  wire logic [3:0] rd_addr = haddr[3:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_ff <= '0;
    end else begin
      aph_ff <= {addr_take, hwrite, haddr[3:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff    <= `GDS_CTRL_RST;
      restart_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= hwdata[`GDS_CTRL_WIDTH-1:0];
      end
      restart_ff <= wr_ctrl & hwdata[`GDS_CTRL_RESTART];
    end
  end

  // ---------------- sequencer state ----------------
  gds_pkg::gds_state_e state_ff;
  gds_pkg::gds_state_e nxt_state;
  logic [7:0]          cnt_ff;
  logic [7:0]          nxt_cnt;
  logic [7:0]          byte_ff;
  logic [15:0]         bytes_ff;
  logic [7:0]          trap_ff;
  logic                irq_prev_ff;

  wire logic trapped = (trap_ff != `GDS_TRAP_NONE);
  wire logic cnt_done = (cnt_ff == 8'h00);

  // read data registered in the address phase so the answer needs no wait state
  wire logic [31:0] rd_status = {16'h0000, 6'h00, state_ff};
  wire logic [31:0] rd_mux =
      (rd_addr == 4'(`GDS_OFS_CTRL))   ? {29'h0000_0000, ctrl_ff} :
      (rd_addr == 4'(`GDS_OFS_STATUS)) ? rd_status :
      (rd_addr == 4'(`GDS_OFS_TRAP))   ? {24'h00_0000, trap_ff} :
      (rd_addr == 4'(`GDS_OFS_BYTES))  ? {16'h0000, bytes_ff} : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (addr_take & ~hwrite) begin
      hrdata_ff <= rd_mux;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  // ---------------- request synchroniser ----------------
  logic q_prev_ff;
  logic sync_hold_ff;
  logic cpu_req_ff;
  logic chreq_ff;

  // eoi blocks the request, chaining ties it to the adapter request, a trap stops it
  wire logic gated_req = dmac_transfer_request & eoi_n
                       & (chreq_ff | ~ctrl_ff.chain)
                       & ~trapped;
  wire logic q_rise   = q_phase & ~q_prev_ff;
  wire logic nxt_hold = q_rise ? gated_req : sync_hold_ff;
  // transparent while q is high, otherwise the captured value stands
  wire logic nxt_cpu_req = q_phase ? gated_req : sync_hold_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_prev_ff    <= 1'b0;
      sync_hold_ff <= 1'b0;
      cpu_req_ff   <= 1'b0;
    end else begin
      q_prev_ff    <= q_phase;
      sync_hold_ff <= nxt_hold;
      cpu_req_ff   <= nxt_cpu_req;
    end
  end
  assign cpu_dma_bus_request = cpu_req_ff;

  // ---------------- grant and dead-cycle select blocking ----------------
  logic       grant_ff;
  logic       dcsb_ff;
  logic [3:0] cs_ff;

  wire logic bus_floated = bus_available & bus_state_line;
  // a one-cycle-late block would let a floating bus strobe a peripheral, hence the quarter pulse
  wire logic nxt_dcsb = (bus_floated & ~dmac_drives_bus) | first_quarter_pulse;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grant_ff <= 1'b0;
      dcsb_ff  <= 1'b1;
      cs_ff    <= 4'h0;
    end else begin
      grant_ff <= bus_floated;
      dcsb_ff  <= nxt_dcsb;
      cs_ff    <= nxt_dcsb ? 4'h0 : periph_select_in;
    end
  end
  assign dmac_grant              = grant_ff;
  assign dead_cycle_select_block = dcsb_ff;
  assign periph_select_out       = cs_ff;

  // ---------------- adapter handshake sequencer ----------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_done ? 8'h00 : cnt_ff - 8'h01;
    case (state_ff)
      gds_pkg::GDS_IDLE: begin
        if (!trapped && ctrl_ff.listen) begin
          nxt_state = gds_pkg::GDS_L_RFD;
        end else if (!trapped && ctrl_ff.talk) begin
          nxt_state = gds_pkg::GDS_T_REQ;
        end
      end
      gds_pkg::GDS_L_RFD: begin
        if (dav_in) begin
          nxt_state = gds_pkg::GDS_L_TAKE;
          nxt_cnt   = 8'(`GDS_ACCEPT_CYC - 1);
        end
      end
      gds_pkg::GDS_L_TAKE: begin
        if (cnt_done) begin
          nxt_state = gds_pkg::GDS_L_WAIT;
          nxt_cnt   = 8'(`GDS_REQ_DELAY_CYC - 1);
        end
      end
      gds_pkg::GDS_L_WAIT: begin
        if (cnt_done) begin
          nxt_state = gds_pkg::GDS_L_REQ;
        end
      end
      gds_pkg::GDS_L_REQ: begin
        if (dma_grant_in) begin
          nxt_state = gds_pkg::GDS_L_DAC;
        end
      end
      gds_pkg::GDS_L_DAC: begin
        if (!dav_in) begin
          nxt_state = gds_pkg::GDS_L_RESET;
          nxt_cnt   = 8'(`GDS_LATCH_RST_CYC - 1);
        end
      end
      gds_pkg::GDS_L_RESET: begin
        if (cnt_done) begin
          nxt_state = gds_pkg::GDS_IDLE;
        end
      end
      gds_pkg::GDS_T_REQ: begin
        if (dma_grant_in) begin
          nxt_state = gds_pkg::GDS_T_DRIVE;
          nxt_cnt   = 8'(`GDS_DAV_DELAY_CYC - 1);
        end
      end
      gds_pkg::GDS_T_DRIVE: begin
        if (cnt_done) begin
          nxt_state = gds_pkg::GDS_T_DAV;
        end
      end
      gds_pkg::GDS_T_DAV: begin
        if (dac_in) begin
          nxt_state = gds_pkg::GDS_IDLE;
        end
      end
      default: begin
        nxt_state = gds_pkg::GDS_IDLE;
      end
    endcase
    // a trap parks the sequencer so no further dma starts
    if (trapped) begin
      nxt_state = gds_pkg::GDS_IDLE;
    end
  end

  wire logic in_listen_take = (state_ff == gds_pkg::GDS_L_TAKE) & cnt_done;
  wire logic dma_cycle      = dma_grant_in & ((state_ff == gds_pkg::GDS_L_REQ) | (state_ff == gds_pkg::GDS_T_REQ));
  wire logic talk_capture   = dma_grant_in & (state_ff == gds_pkg::GDS_T_REQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= gds_pkg::GDS_IDLE;
      cnt_ff   <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // byte holding latch and transfer count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byte_ff  <= 8'h00;
      bytes_ff <= 16'h0000;
    end else begin
      if (in_listen_take) begin
        byte_ff <= gpib_data_in;
      end else if (talk_capture) begin
        byte_ff <= mem_data_in;
      end
      if (restart_ff) begin
        bytes_ff <= 16'h0000;
      end else if (dma_cycle) begin
        bytes_ff <= bytes_ff + 16'h0001;
      end
    end
  end

  // handshake outputs, all registered; strobes from the next state, data from the byte latch and memory bus
  logic rfd_ff;
  logic dac_ff;
  logic dav_ff;
  logic [7:0] gdo_ff;
  logic gdoe_ff;
  logic [7:0] mdo_ff;
  logic [2:0] rsel_ff;
  logic rwinv_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rfd_ff   <= 1'b0;
      dac_ff   <= 1'b0;
      dav_ff   <= 1'b0;
      chreq_ff <= 1'b0;
      gdo_ff   <= 8'h00;
      gdoe_ff  <= 1'b0;
      mdo_ff   <= 8'h00;
      rsel_ff  <= 3'h0;
      rwinv_ff <= 1'b0;
    end else begin
      // ready stands until the byte is actually taken, then falls
      rfd_ff   <= (nxt_state == gds_pkg::GDS_L_RFD) | (nxt_state == gds_pkg::GDS_L_TAKE);
      dac_ff   <= (nxt_state == gds_pkg::GDS_L_DAC);
      dav_ff   <= (nxt_state == gds_pkg::GDS_T_DAV);
      // request falls in the same edge that sees the grant
      chreq_ff <= (nxt_state == gds_pkg::GDS_L_REQ) | (nxt_state == gds_pkg::GDS_T_REQ);
      gdo_ff   <= talk_capture ? mem_data_in : gdo_ff;
      gdoe_ff  <= (nxt_state == gds_pkg::GDS_T_DRIVE) | (nxt_state == gds_pkg::GDS_T_DAV);
      mdo_ff   <= byte_ff;
      // the data register is selected and direction flipped while the request stands
      rsel_ff  <= dma_cycle | (nxt_state == gds_pkg::GDS_L_REQ) | (nxt_state == gds_pkg::GDS_T_REQ)
                  ? `GDS_DATA_REG_IDX : 3'h0;
      rwinv_ff <= dma_cycle | (nxt_state == gds_pkg::GDS_L_REQ) | (nxt_state == gds_pkg::GDS_T_REQ);
    end
  end

  assign rfd_out            = rfd_ff;
  assign dac_out            = dac_ff;
  assign dav_out            = dav_ff;
  assign channel_request_in = chreq_ff;
  assign gpib_data_out      = gdo_ff;
  assign gpib_data_oe       = gdoe_ff;
  assign mem_data_out       = mdo_ff;
  assign reg_select         = rsel_ff;
  assign rw_inverted        = rwinv_ff;

  // ---------------- last byte interrupt and trap classifier ----------------
  logic airq_ff;

  wire logic irq_edge = irq_in & ~irq_prev_ff;
  wire logic e1_hit = (listener_addressed_flag & ~ctrl_ff.listen)
                    | (talker_addressed_flag & ~ctrl_ff.talk);
  wire logic e2_hit = irq_edge & dmac_irq & ~ctrl_ff.talk;
  wire logic e3_hit = irq_edge & ~dmac_irq & ~adapter_int;
  wire logic e4_hit = irq_edge & ~dmac_irq & adapter_int & serial_poll_active_flag;
  // first fault seen wins; irq-path faults take priority when coincident
  wire logic [7:0] nxt_code = e2_hit ? `GDS_TRAP_E2 :
                              e3_hit ? `GDS_TRAP_E3 :
                              e4_hit ? `GDS_TRAP_E4 :
                              e1_hit ? `GDS_TRAP_E1 : `GDS_TRAP_NONE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trap_ff     <= `GDS_TRAP_NONE;
      irq_prev_ff <= 1'b0;
      airq_ff     <= 1'b0;
    end else begin
      irq_prev_ff <= irq_in;
      // a new fault in the restart cycle is kept, so set wins over clear
      if (!trapped || restart_ff) begin
        trap_ff <= nxt_code;
      end
      airq_ff <= ~eoi_n;
    end
  end

  assign adapter_irq  = airq_ff;
  assign trap_display = trap_ff;

endmodule : gds_dma_sync

// ==== gds_dma_sync_regs.svh ====
// register offsets, field positions, reset values and timing counts of the dma request synchroniser
`ifndef GDS_DMA_SYNC_REGS_SVH
`define GDS_DMA_SYNC_REGS_SVH

// register byte addresses
`define GDS_OFS_CTRL        32'h0000_0000
`define GDS_OFS_STATUS      32'h0000_0004
`define GDS_OFS_TRAP        32'h0000_0008
`define GDS_OFS_BYTES       32'h0000_000C
`define GDS_ADDR_BITS       4

// control register fields
`define GDS_CTRL_LISTEN     0
`define GDS_CTRL_TALK       1
`define GDS_CTRL_CHAIN      2
`define GDS_CTRL_RESTART    3
`define GDS_CTRL_WIDTH      3
`define GDS_CTRL_RST        3'h0

// trap display codes
`define GDS_TRAP_NONE       8'h00
`define GDS_TRAP_E1         8'hE1
`define GDS_TRAP_E2         8'hE2
`define GDS_TRAP_E3         8'hE3
`define GDS_TRAP_E4         8'hE4

// selected adapter register during a dma cycle
`define GDS_DATA_REG_IDX    3'h7

// timing, in ns, and cycle counts derived from the clock period
`define GDS_HCLK_NS         100
`define GDS_E_NS            1000
`define GDS_ACCEPT_NS       (2 * `GDS_E_NS)
`define GDS_REQ_DELAY_NS    (7 * `GDS_E_NS / 2)
`define GDS_DAV_DELAY_NS    (3 * `GDS_E_NS / 2)
`define GDS_LATCH_RST_NS    (`GDS_E_NS)
`define GDS_ACCEPT_CYC      ((`GDS_ACCEPT_NS + `GDS_HCLK_NS - 1) / `GDS_HCLK_NS)
`define GDS_REQ_DELAY_CYC   ((`GDS_REQ_DELAY_NS + `GDS_HCLK_NS - 1) / `GDS_HCLK_NS)
`define GDS_DAV_DELAY_CYC   ((`GDS_DAV_DELAY_NS + `GDS_HCLK_NS - 1) / `GDS_HCLK_NS)
`define GDS_LATCH_RST_CYC   ((`GDS_LATCH_RST_NS + `GDS_HCLK_NS - 1) / `GDS_HCLK_NS)

`endif

// ==== gds_pkg.sv ====
// types shared by the dma request synchroniser
package gds_pkg;

  // adapter handshake sequencer, one-hot
  typedef enum logic [9:0] {
    GDS_IDLE     = 10'b00_0000_0001,
    GDS_L_RFD    = 10'b00_0000_0010,
    GDS_L_TAKE   = 10'b00_0000_0100,
    GDS_L_WAIT   = 10'b00_0000_1000,
    GDS_L_REQ    = 10'b00_0001_0000,
    GDS_L_DAC    = 10'b00_0010_0000,
    GDS_L_RESET  = 10'b00_0100_0000,
    GDS_T_REQ    = 10'b00_1000_0000,
    GDS_T_DRIVE  = 10'b01_0000_0000,
    GDS_T_DAV    = 10'b10_0000_0000
  } gds_state_e;

  // software control bits
  typedef struct packed {
    logic chain;
    logic talk;
    logic listen;
  } gds_ctrl_s;

  // captured ahb address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [3:0] addr;
  } gds_aphase_s;

endpackage : gds_pkg

// ==== gds_dma_sync_checker.sv ====
// concurrent checks on the ports of the dma request synchroniser
`timescale 1ns/100ps
module gds_dma_sync_checker (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // bus and processor side
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       q_phase,
  input wire logic       first_quarter_pulse,
  input wire logic       bus_available,
  input wire logic       bus_state_line,
  input wire logic       dmac_drives_bus,
  input wire logic       cpu_dma_bus_request,
  input wire logic       dmac_grant,
  input wire logic       dead_cycle_select_block,
  // controller and adapter side
  input wire logic       dmac_transfer_request,
  input wire logic       dma_grant_in,
  input wire logic       channel_request_in,
  input wire logic [2:0] reg_select,
  input wire logic       rw_inverted,
  input wire logic       eoi_n,
  input wire logic       dav_in,
  input wire logic       rfd_out,
  input wire logic       dav_out,
  input wire logic       gpib_data_oe,
  input wire logic       adapter_irq,
  input wire logic [7:0] trap_display
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_grant_and: assert property (1 |=> dmac_grant == $past(bus_available && bus_state_line))
    else $error("grant is not the and of the bus signals");
  a_eoi_block: assert property (!eoi_n && q_phase |=> !cpu_dma_bus_request)
    else $error("request passed while end is marked");
  a_sync_pass: assert property (q_phase && dmac_transfer_request && eoi_n && channel_request_in |=> cpu_dma_bus_request)
    else $error("request not passed in high offset phase");
  a_sync_drop: assert property (q_phase && !dmac_transfer_request |=> !cpu_dma_bus_request)
    else $error("request kept in high offset phase");
  a_grant_drop: assert property (channel_request_in && dma_grant_in |=> !channel_request_in)
    else $error("adapter request kept after grant");
  a_reg_seven: assert property (channel_request_in |-> reg_select == 3'h7 && rw_inverted)
    else $error("data register not selected during request");
  a_irq_follow: assert property (1 |=> adapter_irq == !$past(eoi_n))
    else $error("adapter irq does not follow end");
  a_quarter_block: assert property (first_quarter_pulse |=> dead_cycle_select_block)
    else $error("first quarter not blocked");
  a_dead_block: assert property (bus_available && bus_state_line && !dmac_drives_bus |=> dead_cycle_select_block)
    else $error("dead cycle not blocked");
  a_rfd_drop: assert property (rfd_out && dav_in |-> ##[1:24] !rfd_out)
    else $error("ready for data not dropped");
  a_dav_gap: assert property ($rose(gpib_data_oe) |-> !dav_out [*8] ##[6:9] dav_out)
    else $error("data valid spacing wrong");
  a_trap_hold: assert property ($past(trap_display) != 8'h00
    && !$past(hsel && htrans[1] && hwrite && hready, 3) |-> trap_display == $past(trap_display))
    else $error("trap code changed without restart");
  a_reset_clear: assert property ($rose(hresetn) |-> !cpu_dma_bus_request)
    else $error("request pending after reset");
endmodule : gds_dma_sync_checker

bind gds_dma_sync gds_dma_sync_checker i_chk (.*);

// ==== gds_far_model.sv ====
// processor and dma controller model facing the synchroniser
`timescale 1ns/100ps
module gds_far_model (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // bench controls
  input wire logic       slow,
  input wire logic [7:0] tx_byte,
  // from the synchroniser
  input wire logic       channel_request_in,
  input wire logic       cpu_dma_bus_request,
  // to the synchroniser
  output logic           dmac_transfer_request,
  output logic           bus_available,
  output logic           bus_state_line,
  output logic           dmac_drives_bus,
  output logic           dma_grant_in,
  output logic           q_phase,
  output logic [7:0]     mem_data_in
);
  logic [4:0] req_dly_ff;
  logic [2:0] step_ff;
  logic [1:0] q_cnt_ff;

  // slow mode lets the request linger, as a sluggish controller would
  assign dmac_transfer_request = slow ? req_dly_ff[4] : req_dly_ff[2];
  assign q_phase               = q_cnt_ff[1];
  // steps: 1 pre dead, 2 address out, 3 strobe, 4 post dead, 5 wait for release
  assign bus_available         = step_ff inside {3'h1, 3'h2, 3'h3, 3'h4};
  assign bus_state_line        = bus_available;
  assign dmac_drives_bus       = step_ff inside {3'h2, 3'h3};
  assign dma_grant_in          = step_ff == 3'h3;
  // off the bus the byte is inverted so a stale sample cannot pass
  assign mem_data_in           = dmac_drives_bus ? tx_byte : ~tx_byte;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_dly_ff <= 5'h00;
      step_ff    <= 3'h0;
      q_cnt_ff   <= 2'h0;
    end else begin
      req_dly_ff <= {req_dly_ff[3:0], channel_request_in};
      q_cnt_ff   <= q_cnt_ff + 2'h1;
      if (step_ff == 3'h0) begin
        step_ff <= {2'h0, cpu_dma_bus_request};
      end else if (step_ff == 3'h5) begin
        step_ff <= cpu_dma_bus_request ? 3'h5 : 3'h0;
      end else begin
        step_ff <= step_ff + 3'h1;
      end
    end
  end
endmodule : gds_far_model

// ==== gds_tb.sv ====
// self-checking bench for the dma request synchroniser
`timescale 1ns/100ps
`include "gds_dma_sync_regs.svh"
module tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, reg_select;
  logic        q_phase, first_quarter_pulse, bus_available, bus_state_line, dmac_drives_bus;
  logic [3:0]  periph_select_in, periph_select_out;
  logic        cpu_dma_bus_request, dmac_grant, dead_cycle_select_block, dmac_transfer_request;
  logic        dma_grant_in, dmac_irq, channel_request_in, rw_inverted, eoi_n, dav_in, dac_in;
  logic [7:0]  mem_data_in, mem_data_out, gpib_data_in, gpib_data_out, trap_display, tx_byte;
  logic        rfd_out, dac_out, dav_out, gpib_data_oe, irq_in, adapter_int, adapter_irq;
  logic        listener_addressed_flag, talker_addressed_flag, serial_poll_active_flag;
  int          fail_count, checked, n;

  gds_dma_sync  i_dut (.hready(hreadyout), .*);
  gds_far_model i_far (.*);

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic t_regs;
    ahb(1'b0, `GDS_OFS_STATUS, 32'h0000_0000);
    check("status reset", rd, 32'h0000_0001);
    ahb(1'b1, `GDS_OFS_CTRL, 32'h0000_0004);
    ahb(1'b0, `GDS_OFS_CTRL, 32'h0000_0000);
    check("ctrl readback", rd, 32'h0000_0004);
    ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
    check("alias read", rd, 32'h0000_0004);
    check("okay response", hresp, 1'b0);
    ahb(1'b1, `GDS_OFS_CTRL, 32'h0000_0000);
    first_quarter_pulse <= 1'b1;
    repeat (2) @(posedge hclk);
    check("quarter block", dead_cycle_select_block, 1'b1);
    check("selects gated", periph_select_out, 4'h0);
    first_quarter_pulse <= 1'b0;
    repeat (2) @(posedge hclk);
    check("selects open", periph_select_out, 4'hB);
    $display("register test done");
  endtask : t_regs

  task automatic t_listen;
    ahb(1'b1, `GDS_OFS_CTRL, 32'h0000_0001);
    while (rfd_out !== 1'b1) @(posedge hclk);
    gpib_data_in <= 8'hA5;
    dav_in       <= 1'b1;
    n = 0;
    while (channel_request_in !== 1'b1) begin
      @(posedge hclk);
      n++;
      if (n == 25) check("rfd after byte", rfd_out, 1'b0);
    end
    check("request delay", n >= 54 && n <= 58, 1'b1);
    check("data register", reg_select, 3'h7);
    check("rw inverted", rw_inverted, 1'b1);
    while (dac_out !== 1'b1) @(posedge hclk);
    check("byte stored", mem_data_out, 8'hA5);
    check("request gone", channel_request_in, 1'b0);
    gpib_data_in <= 8'h5A;
    dav_in       <= 1'b0;
    n = 0;
    while (rfd_out !== 1'b1) begin
      @(posedge hclk);
      n++;
    end
    check("latch reset", n >= 10 && n <= 13, 1'b1);
    ahb(1'b0, `GDS_OFS_BYTES, 32'h0000_0000);
    check("byte count", rd, 32'h0000_0001);
    $display("listener test done");
  endtask : t_listen

  task automatic t_trap;
    // bits: listener addressed, controller irq, adapter irq, poll active, irq pulse
    logic [4:0] cause [4];
    cause = '{5'h10, 5'h09, 5'h01, 5'h07};
    ahb(1'b1, `GDS_OFS_CTRL, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      {listener_addressed_flag, dmac_irq, adapter_int, serial_poll_active_flag, irq_in} <= cause[i];
      @(posedge hclk);
      irq_in <= 1'b0;
      repeat (3) @(posedge hclk);
      check("trap code", trap_display, 8'hE1 + 8'(i));
      {listener_addressed_flag, dmac_irq, adapter_int, serial_poll_active_flag} <= 4'h0;
      repeat (4) @(posedge hclk);
      check("trap held", trap_display, 8'hE1 + 8'(i));
      ahb(1'b0, `GDS_OFS_STATUS, 32'h0000_0000);
      check("trap idle", rd, 32'h0000_0001);
      ahb(1'b1, `GDS_OFS_CTRL, 32'h0000_0008);
      repeat (2) @(posedge hclk);
      check("trap cleared", trap_display, 8'h00);
    end
    $display("trap test done");
  endtask : t_trap

  task automatic t_talk;
    eoi_n   <= 1'b0;
    slow    <= 1'b1;
    tx_byte <= 8'h3C;
    ahb(1'b1, `GDS_OFS_CTRL, 32'h0000_0006);
    while (channel_request_in !== 1'b1) @(posedge hclk);
    repeat (10) @(posedge hclk);
    check("held off", cpu_dma_bus_request, 1'b0);
    check("end irq", adapter_irq, 1'b1);
    eoi_n <= 1'b1;
    while (dma_grant_in !== 1'b1) @(posedge hclk);
    repeat (5) @(posedge hclk);
    check("chain release", cpu_dma_bus_request, 1'b0);
    check("byte driven", gpib_data_out, 8'h3C);
    check("drive enable", gpib_data_oe, 1'b1);
    n = 0;
    while (dav_out !== 1'b1) begin
      @(posedge hclk);
      n++;
    end
    check("dav delay", n >= 9 && n <= 14, 1'b1);
    dac_in <= 1'b1;
    repeat (4) @(posedge hclk);
    check("next request", channel_request_in, 1'b1);
    dac_in <= 1'b0;
    $display("talker test done");
  endtask : t_talk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, first_quarter_pulse, dmac_irq, dav_in, dac_in} = '0;
    {irq_in, adapter_int, listener_addressed_flag, talker_addressed_flag, serial_poll_active_flag, slow} = '0;
    {hsize, eoi_n, periph_select_in, gpib_data_in, tx_byte} = {3'h2, 1'b1, 4'hB, 16'h0000};
    fail_count = 0;
    checked = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_listen;
    t_trap;
    t_talk;
    give_verdict;
  end

  // the whole run takes well under a thousand cycles
  initial begin
    #3_000_000;
    fail_count++;
    give_verdict;
  end
endmodule : tb
